/* scsi_consts.vh */
`ifndef SCSI_CONSTS_VH
`define SCSI_CONSTS_VH
// ****************************************
// register byte addresses
// ****************************************
`define SCSI_ADDR_REQ_FLAGS   12'h000
`define SCSI_ADDR_MASK_FLAGS  12'h004
`define SCSI_ADDR_START_TRIG  12'h008
`define SCSI_ADDR_ENABLE_STAT 12'h00C
`define SCSI_ADDR_RX_ENABLE   12'h010
// ****************************************
// field positions
// ****************************************
`define SCSI_BIT_RX_ERR       7
`define SCSI_BIT_RX_END       6
`define SCSI_BIT_TX_END       5
`define SCSI_NUM_CH           4
// ****************************************
// reset values
// ****************************************
`define SCSI_RST_REQ_FLAGS    8'h00
`define SCSI_RST_MASK_FLAGS   8'hFF
`define SCSI_RST_CH           4'h0
// ****************************************
// timing: least gap receive enable to start
// ****************************************
`define SCSI_RXE_GAP_CYC      4
`endif

/* scsi_event_sync.v */
`timescale 1ns/1ps
// ****************************************
// three-stage synchroniser with rising-edge pulse
// ****************************************
module scsi_event_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output wire pulse
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  reg lvl_r;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= 1'b0;
      s2_r  <= 1'b0;
      s3_r  <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        lvl_r <= s3_r;
    end
  end

  assign pulse = (s2_r == s3_r) && s3_r && !lvl_r;
endmodule // scsi_event_sync

/* scsi_start_irq.v */
`include "scsi_consts.vh"
`timescale 1ns/1ps
module scsi_start_irq (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        rx_end_event,
  input  wire        tx_end_event,
  input  wire        rx_error_event,
  input  wire [3:0]  channel_stop,
  output wire [3:0]  channel_enable_status,
  output wire [3:0]  comm_wait,
  output wire [3:0]  receive_enable_bit,
  output wire        rx_error_irq,
  output wire        rx_end_interrupt,
  output wire        tx_end_interrupt,
  output wire        irq
);
  // ****************************************
  // state
  // ****************************************
  reg  [7:0] req_r;
  reg  [7:0] req_nxt;
  reg  [7:0] mask_r;
  reg  [3:0] enable_r;
  reg  [3:0] enable_nxt;
  reg  [3:0] rxe_r;
  reg  [3:0] start_pulse_r;
  wire       wr;
  wire       rd;
  wire       ev_rx_end;
  wire       ev_tx_end;
  wire       ev_rx_err;
  wire [7:0] set_vec;

  // address decode used in both read and write paths
  function hit;
    input [11:0] a;
    input [11:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ****************************************
  // event synchronisers
  // ****************************************
  scsi_event_sync u_sync_rx_end (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (rx_end_event),
    .pulse   (ev_rx_end)
  );
  scsi_event_sync u_sync_tx_end (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (tx_end_event),
    .pulse   (ev_tx_end)
  );
  scsi_event_sync u_sync_rx_err (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (rx_error_event),
    .pulse   (ev_rx_err)
  );

  // event vector in flag-register layout
  assign set_vec = ({7'h00, ev_rx_err} << `SCSI_BIT_RX_ERR) |
                   ({7'h00, ev_rx_end} << `SCSI_BIT_RX_END) |
                   ({7'h00, ev_tx_end} << `SCSI_BIT_TX_END);

  // ****************************************
  // request flags: set wins over clear
  // ****************************************
  always @* begin
    req_nxt = req_r;
    if (wr && hit(paddr, `SCSI_ADDR_REQ_FLAGS))
      req_nxt = req_r & ~pwdata[7:0];
    req_nxt = (req_nxt | set_vec) & set_vec_mask(1'b1);
  end

  // only the three event flag positions exist
  function [7:0] set_vec_mask;
    input dummy;
    begin
      set_vec_mask = 8'h00;
      set_vec_mask[`SCSI_BIT_RX_ERR] = dummy;
      set_vec_mask[`SCSI_BIT_RX_END] = dummy;
      set_vec_mask[`SCSI_BIT_TX_END] = dummy;
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      req_r <= `SCSI_RST_REQ_FLAGS;
    else
      req_r <= req_nxt;
  end

  // ****************************************
  // mask and receive enable registers
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `SCSI_RST_MASK_FLAGS;
      rxe_r  <= `SCSI_RST_CH;
    end else begin
      if (wr && hit(paddr, `SCSI_ADDR_MASK_FLAGS))
        mask_r <= pwdata[7:0] | ~set_vec_mask(1'b1);
      if (wr && hit(paddr, `SCSI_ADDR_RX_ENABLE))
        rxe_r <= pwdata[3:0];
    end
  end

  // ****************************************
  // start trigger and channel enable
  // ****************************************
  always @* begin
    enable_nxt = enable_r & ~channel_stop;
    if (wr && hit(paddr, `SCSI_ADDR_START_TRIG))
      enable_nxt = enable_nxt | pwdata[3:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r      <= `SCSI_RST_CH;
      start_pulse_r <= `SCSI_RST_CH;
    end else begin
      enable_r <= enable_nxt;
      if (wr && hit(paddr, `SCSI_ADDR_START_TRIG))
        start_pulse_r <= pwdata[3:0];
      else
        start_pulse_r <= 4'h0;
    end
  end

  // comm wait: enabled channels after their start
  assign comm_wait             = enable_r;
  assign channel_enable_status = enable_r;
  assign receive_enable_bit    = rxe_r; // start spacing is kept by software

  // ****************************************
  // interrupt outputs, mask 0 passes
  // ****************************************
  assign rx_error_irq     = req_r[`SCSI_BIT_RX_ERR] & ~mask_r[`SCSI_BIT_RX_ERR];
  assign rx_end_interrupt = req_r[`SCSI_BIT_RX_END] & ~mask_r[`SCSI_BIT_RX_END];
  assign tx_end_interrupt = req_r[`SCSI_BIT_TX_END] & ~mask_r[`SCSI_BIT_TX_END];
  assign irq = rx_error_irq | rx_end_interrupt | tx_end_interrupt;

  // ****************************************
  // read data
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd && !penable) begin
      if (hit(paddr, `SCSI_ADDR_REQ_FLAGS))
        prdata <= {24'h00_0000, req_r};
      else if (hit(paddr, `SCSI_ADDR_MASK_FLAGS))
        prdata <= {24'h00_0000, mask_r};
      else if (hit(paddr, `SCSI_ADDR_ENABLE_STAT))
        prdata <= {28'h000_0000, enable_r};
      else if (hit(paddr, `SCSI_ADDR_RX_ENABLE))
        prdata <= {28'h000_0000, rxe_r};
      else
        prdata <= 32'h0000_0000; // start trigger reads 0
    end
  end
endmodule // scsi_start_irq

/* scsi_start_irq_props.sv */
`timescale 1ns/1ps
`include "scsi_consts.vh"
// ****
// port checker
// ****
module scsi_start_irq_props (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic [3:0]  channel_enable_status,
  input logic [3:0]  comm_wait,
  input logic        rx_error_irq,
  input logic        rx_end_interrupt,
  input logic        tx_end_interrupt,
  input logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write access decode
  wire wr = psel && penable && pwrite;
  wire st = wr && paddr == `SCSI_ADDR_START_TRIG;
  sequence start_wr;
    st;
  endsequence
  a_start_sets: assert property (
    start_wr |=> &(channel_enable_status | ~$past(pwdata[3:0]))) else $error("start lost");
  a_no_trig: assert property (
    !st |=> !(channel_enable_status & ~$past(channel_enable_status))) else $error("stray start");
  a_comm_wait: assert property (
    comm_wait == channel_enable_status) else $error("wait state differs");
  a_irq_any: assert property (
    irq == (rx_error_irq | rx_end_interrupt | tx_end_interrupt)) else $error("irq not or");
  a_err_sticky: assert property (
    rx_error_irq && !wr |=> rx_error_irq) else $error("error flag lost");
  a_end_sticky: assert property (
    rx_end_interrupt && !wr |=> rx_end_interrupt) else $error("rx end flag lost");
  a_tx_sticky: assert property (
    tx_end_interrupt && !wr |=> tx_end_interrupt) else $error("tx end flag lost");
  a_start_rd0: assert property (
    psel && !penable && !pwrite && st == 0 && paddr == `SCSI_ADDR_START_TRIG
    |=> prdata == 32'h0000_0000) else $error("start reg not 0");
endmodule // scsi_start_irq_props
bind scsi_start_irq scsi_start_irq_props u_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .channel_enable_status, .comm_wait, .rx_error_irq, .rx_end_interrupt,
  .tx_end_interrupt, .irq
);

/* scsi_start_irq_tb_top.sv */
`timescale 1ns/1ps
`include "scsi_consts.vh"
module scsi_start_irq_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, irq, rx_error_irq, rx_end_interrupt, tx_end_interrupt;
  logic [2:0]  ev = '0;
  logic [3:0]  channel_stop = '0, channel_enable_status, comm_wait, receive_enable_bit;
  integer      miscompares = 0, total_checks = 0, fl, mk, en, v, i;
  always #2.5 pclk = ~pclk;
  scsi_start_irq DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_end_event(ev[1]), .tx_end_event(ev[0]), .rx_error_event(ev[2]),
    .channel_stop, .channel_enable_status, .comm_wait, .receive_enable_bit, .rx_error_irq,
    .rx_end_interrupt, .tx_end_interrupt, .irq);
  // ****
  // tasks
  // ****
  task chk(input [31:0] s, input [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // one apb transfer, bounded wait for pready
  task xf(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n++;
        @(posedge pclk);
      end
      if (n >= 20) begin
        miscompares++;
        final_report;
      end
      rd = prdata;
      chk(pslverr, 0);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(68133));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    mk = `SCSI_RST_MASK_FLAGS;
    xf(0, `SCSI_ADDR_REQ_FLAGS, 0);
    chk(rd, `SCSI_RST_REQ_FLAGS);
    xf(0, `SCSI_ADDR_MASK_FLAGS, 0);
    chk(rd, mk);
    xf(1, 12'h020, 32'hFFFF_FFFF);
    xf(0, 12'h020, 0);
    chk(rd, 0);
    $display("reset test done");
    for (i = 0; i < 3; i++) begin
      ev[i] <= 1'b1;
      repeat (8) @(posedge pclk);
      ev[i] <= 1'b0;
      fl = 1 << (`SCSI_BIT_TX_END + i);
      xf(0, `SCSI_ADDR_REQ_FLAGS, 0);
      chk(rd, fl);
      chk(irq, 0);
      mk = mk ^ fl;
      xf(1, `SCSI_ADDR_MASK_FLAGS, mk);
      chk({rx_error_irq, rx_end_interrupt, tx_end_interrupt}, 1 << i);
      xf(1, `SCSI_ADDR_REQ_FLAGS, fl);
      chk(irq, 0);
      mk = mk ^ fl;
      xf(1, `SCSI_ADDR_MASK_FLAGS, mk);
    end
    xf(1, `SCSI_ADDR_REQ_FLAGS, 32'h0000_00E0);
    xf(1, `SCSI_ADDR_MASK_FLAGS, 32'h0000_001F);
    chk(irq, 0);
    xf(1, `SCSI_ADDR_MASK_FLAGS, mk);
    $display("event test done");
    en = 0;
    for (i = 0; i < 3; i++) begin
      v = $urandom;
      en = en | (v & 15);
      xf(1, `SCSI_ADDR_START_TRIG, v);
      xf(0, `SCSI_ADDR_ENABLE_STAT, 0);
      chk(rd, en);
      xf(0, `SCSI_ADDR_START_TRIG, 0);
      chk(rd, 0);
    end
    channel_stop <= 4'hF;
    @(posedge pclk) channel_stop <= 4'h0;
    xf(0, `SCSI_ADDR_ENABLE_STAT, 0);
    chk(rd, 0);
    xf(1, `SCSI_ADDR_RX_ENABLE, 1);
    chk(receive_enable_bit, 1);
    repeat (`SCSI_RXE_GAP_CYC) @(posedge pclk);
    xf(1, `SCSI_ADDR_START_TRIG, 1);
    chk(comm_wait, 1);
    $display("start test done");
    final_report;
  end
endmodule // scsi_start_irq_tb_top
